/* logic/iex_core.sv */
// Execution unit for halt, push, return, rotate-right and the two subtracts,
// with working register, flags, PC, watchdog counter and AXI4-Lite slave.
// Assumes a single 10 MHz clock and a well-behaved AXI4-Lite master.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module iex_core
  import iex_pkg::*;
(
  input  wire logic                  clock,          // Core clock
  input  wire logic                  rstn,           // Sync reset, low
  input  wire logic                  ce,             // Clock enable
  input  wire logic [IEX_AXI_AW-1:0] s_axi_awaddr,   // Write address
  input  wire logic                  s_axi_awvalid,  // Write addr valid
  output logic                       s_axi_awready,  // Write addr ready
  input  wire logic [31:0]           s_axi_wdata,    // Write data
  input  wire logic [3:0]            s_axi_wstrb,    // Byte enables
  input  wire logic                  s_axi_wvalid,   // Write data valid
  output logic                       s_axi_wready,   // Write data ready
  output logic [1:0]                 s_axi_bresp,    // Write response
  output logic                       s_axi_bvalid,   // Response valid
  input  wire logic                  s_axi_bready,   // Response ready
  input  wire logic [IEX_AXI_AW-1:0] s_axi_araddr,   // Read address
  input  wire logic                  s_axi_arvalid,  // Read addr valid
  output logic                       s_axi_arready,  // Read addr ready
  output logic [31:0]                s_axi_rdata,    // Read data
  output logic [1:0]                 s_axi_rresp,    // Read response
  output logic                       s_axi_rvalid,   // Read data valid
  input  wire logic                  s_axi_rready,   // Read data ready
  output logic                       osc_run         // Oscillator enable
);

  // ****************************************************************
  // State
  // ****************************************************************
  iex_state_e                 ex_state_reg, ex_state_next;
  iex_cmd_s                   cmd_reg, cmd_next;
  iex_flags_s                 flags_reg, flags_next;
  logic [IEX_DATA_W-1:0]      w_reg, w_next;
  logic [IEX_PC_W-1:0]        pc_reg, pc_next;
  logic [IEX_WDOG_W-1:0]      watchdog_counter_reg, watchdog_counter_next;
  logic [IEX_PRE_W-1:0]       pre_reg, pre_next;
  logic [IEX_FADDR_W-1:0]     faddr_reg, faddr_next;
  logic                       osc_run_reg, osc_run_next;

  logic                       aw_held_reg, aw_held_next;
  logic                       w_held_reg, w_held_next;
  logic [IEX_AXI_AW-1:0]      awaddr_reg, awaddr_next;
  logic [31:0]                wdata_reg, wdata_next;
  logic [3:0]                 wstrb_reg, wstrb_next;
  logic                       bvalid_reg, bvalid_next;
  logic [1:0]                 bresp_reg, bresp_next;
  logic [IEX_AXI_AW-1:0]      araddr_reg, araddr_next;
  logic [1:0]                 rphase_reg, rphase_next;
  logic                       rvalid_reg, rvalid_next;
  logic [31:0]                rdata_reg, rdata_next;
  logic [1:0]                 rresp_reg, rresp_next;
  logic                       awready_reg, awready_next;
  logic                       wready_reg, wready_next;
  logic                       arready_reg, arready_next;

  // ****************************************************************
  // Shared combinational terms
  // ****************************************************************
  logic                       busy;
  logic                       wr_commit;
  logic [31:0]                wr_mask;
  logic [31:0]                wr_val;
  logic                       mem_we;
  logic [IEX_FADDR_W-1:0]     mem_waddr;
  logic [IEX_DATA_W-1:0]      mem_wdata;
  logic [IEX_FADDR_W-1:0]     mem_raddr;
  logic [IEX_DATA_W-1:0]      mem_rdata;
  logic                       stk_push;
  logic                       stk_pop;
  logic [IEX_PC_W-1:0]        stack_head_entry;

  assign busy = (ex_state_reg == IEX_EX_FETCH) ||
                (ex_state_reg == IEX_EX_EXEC) ||
                (ex_state_reg == IEX_EX_RET2);
  // Bus writes wait while an instruction owns the flags and memory
  assign wr_commit = aw_held_reg && w_held_reg && !bvalid_reg && !busy;
  assign wr_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                    {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  // Fetch cycle owns the read port; bus reads of file data wait for it
  assign mem_raddr = (ex_state_reg == IEX_EX_FETCH) ? cmd_reg.faddr
                                                   : faddr_reg;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      IEX_OFS_CMD:    v = {12'h000, cmd_reg};
      IEX_OFS_WREG:   v = {24'h00_0000, w_reg};
      IEX_OFS_STATUS: begin
        v[IEX_FLAGS_W-1:0] = flags_reg;
        v[IEX_ST_BUSY]     = busy;
        v[IEX_ST_HALT]     = (ex_state_reg == IEX_EX_HALT);
      end
      IEX_OFS_PC:     v = {19'h0_0000, pc_reg};
      IEX_OFS_WDOG:   v = {16'h0000, watchdog_counter_reg, pre_reg};
      IEX_OFS_FADDR:  v = {25'h000_0000, faddr_reg};
      IEX_OFS_FDATA:  v = {24'h00_0000, mem_rdata};
      default:        v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_read

  function automatic logic reg_mapped(input logic [7:0] a);
    return (a <= IEX_OFS_WAKE) && (a[1:0] == 2'h0);
  endfunction : reg_mapped

  assign wr_val = (reg_read(awaddr_reg) & ~wr_mask) | (wdata_reg & wr_mask);

  // ****************************************************************
  // Execution unit
  // ****************************************************************
  logic [8:0] sub_full;
  logic [4:0] sub_low;
  logic [7:0] sub_lhs;
  logic [7:0] result;
  logic       result_to_file;

  always_comb begin
    ex_state_next         = ex_state_reg;
    cmd_next              = cmd_reg;
    flags_next            = flags_reg;
    w_next                = w_reg;
    pc_next               = pc_reg;
    faddr_next            = faddr_reg;
    osc_run_next          = (ex_state_reg != IEX_EX_HALT);
    stk_push              = 1'b0;
    stk_pop               = 1'b0;
    result                = 8'h00;
    result_to_file        = 1'b0;
    sub_lhs = (cmd_reg.op == IEX_SUBTRACT_LITERAL_INSTR) ? cmd_reg.literal
                                                         : mem_rdata;
    sub_full = {1'b0, sub_lhs} - {1'b0, w_reg};
    sub_low  = {1'b0, sub_lhs[3:0]} - {1'b0, w_reg[3:0]};
    // Watchdog ticks only while the oscillator runs
    pre_next              = pre_reg;
    watchdog_counter_next = watchdog_counter_reg;
    if (ex_state_reg != IEX_EX_HALT) begin
      pre_next = pre_reg + 8'h01;
      if (pre_reg == 8'hff) begin
        watchdog_counter_next = watchdog_counter_reg + 8'h01;
      end
    end

    case (ex_state_reg)
      IEX_EX_IDLE: begin
        if (wr_commit && awaddr_reg == IEX_OFS_CMD) begin
          cmd_next      = iex_cmd_s'(wr_val[IEX_CMD_W-1:0]);
          ex_state_next = IEX_EX_FETCH;
        end
      end
      IEX_EX_FETCH: begin
        ex_state_next = IEX_EX_EXEC;
      end
      IEX_EX_EXEC: begin
        pc_next       = pc_reg + 13'h0001;
        ex_state_next = IEX_EX_IDLE;
        case (cmd_reg.op)
          IEX_OP_SLEEP: begin
            watchdog_counter_next = IEX_WDOG_CLR;
            pre_next              = IEX_PRE_CLR;
            flags_next.power_down_flag_n      = 1'b0;
            flags_next.watchdog_expiry_flag_n = 1'b1;
            osc_run_next          = 1'b0;
            ex_state_next         = IEX_EX_HALT;
          end
          IEX_OP_RETURN: begin
            stk_pop       = 1'b1;
            pc_next       = stack_head_entry;
            ex_state_next = IEX_EX_RET2;
          end
          IEX_ROTATE_RIGHT_CARRY_INSTR: begin
            result = {flags_reg.carry_flag, mem_rdata[7:1]};
            flags_next.carry_flag = mem_rdata[0];
            result_to_file = cmd_reg.dest;
            if (!cmd_reg.dest) begin
              w_next = result;
            end
          end
          IEX_SUBTRACT_LITERAL_INSTR, IEX_SUBTRACT_FILE_INSTR: begin
            result = sub_full[7:0];
            flags_next.carry_flag       = ~sub_full[8];
            flags_next.digit_carry_flag = ~sub_low[4];
            flags_next.zero_flag        = (sub_full[7:0] == 8'h00);
            result_to_file = (cmd_reg.op == IEX_SUBTRACT_FILE_INSTR) &&
                             cmd_reg.dest;
            if (!result_to_file) begin
              w_next = result;
            end
          end
          IEX_OP_PUSH: begin
            stk_push = 1'b1;
          end
          default: begin
          end
        endcase
      end
      IEX_EX_RET2: begin
        ex_state_next = IEX_EX_IDLE;
      end
      IEX_EX_HALT: begin
        if (wr_commit && awaddr_reg == IEX_OFS_WAKE &&
            wr_val[IEX_WAKE_BIT]) begin
          ex_state_next = IEX_EX_IDLE;
          osc_run_next  = 1'b1;
        end
      end
      default: begin
        ex_state_next = IEX_EX_IDLE;
      end
    endcase

    // Software writes land only while no instruction is in flight
    if (wr_commit) begin
      case (awaddr_reg)
        IEX_OFS_WREG:   w_next     = wr_val[7:0];
        IEX_OFS_STATUS: flags_next = iex_flags_s'(wr_val[IEX_FLAGS_W-1:0]);
        IEX_OFS_PC:     pc_next    = wr_val[IEX_PC_W-1:0];
        IEX_OFS_FADDR:  faddr_next = wr_val[IEX_FADDR_W-1:0];
        default: begin
        end
      endcase
    end
  end

  assign mem_we    = result_to_file ||
                     (wr_commit && awaddr_reg == IEX_OFS_FDATA);
  assign mem_waddr = result_to_file ? cmd_reg.faddr : faddr_reg;
  assign mem_wdata = result_to_file ? result : wr_val[7:0];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ex_state_reg         <= IEX_EX_IDLE;
      cmd_reg              <= '0;
      flags_reg            <= IEX_FLAGS_RST;
      w_reg                <= IEX_W_RST;
      pc_reg               <= IEX_PC_RST;
      watchdog_counter_reg <= IEX_WDOG_CLR;
      pre_reg              <= IEX_PRE_CLR;
      faddr_reg            <= '0;
      osc_run_reg          <= 1'b1;
    end else if (ce) begin
      ex_state_reg         <= ex_state_next;
      cmd_reg              <= cmd_next;
      flags_reg            <= flags_next;
      w_reg                <= w_next;
      pc_reg               <= pc_next;
      watchdog_counter_reg <= watchdog_counter_next;
      pre_reg              <= pre_next;
      faddr_reg            <= faddr_next;
      osc_run_reg          <= osc_run_next;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    araddr_next  = araddr_reg;
    rphase_next  = rphase_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_commit) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = IEX_RESP_OKAY;
      if (!reg_mapped(awaddr_reg) || awaddr_reg == IEX_OFS_WDOG ||
          (awaddr_reg == IEX_OFS_CMD && ex_state_reg == IEX_EX_HALT)) begin
        bresp_next = IEX_RESP_SLVERR;
      end
    end
    // Phase 1 drives the file address, phase 2 captures the data
    case (rphase_reg)
      2'h0: begin
        if (s_axi_arvalid && !rvalid_reg) begin
          araddr_next = s_axi_araddr;
          rphase_next = 2'h1;
        end
      end
      2'h1: begin
        if (ex_state_reg != IEX_EX_FETCH) begin
          rphase_next = 2'h2;
        end
      end
      2'h2: begin
        rphase_next = 2'h0;
        rvalid_next = 1'b1;
        rdata_next  = reg_read(araddr_reg);
        rresp_next  = reg_mapped(araddr_reg) ? IEX_RESP_OKAY
                                             : IEX_RESP_SLVERR;
      end
      default: begin
        rphase_next = 2'h0;
      end
    endcase
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    // Ready lines registered so every port leaves a flop
    awready_next = !aw_held_next;
    wready_next  = !w_held_next;
    arready_next = (rphase_next == 2'h0) && !rvalid_next;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= IEX_RESP_OKAY;
      araddr_reg  <= '0;
      rphase_reg  <= 2'h0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= IEX_RESP_OKAY;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      arready_reg <= 1'b1;
    end else if (ce) begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      araddr_reg  <= araddr_next;
      rphase_reg  <= rphase_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      arready_reg <= arready_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign osc_run       = osc_run_reg;

  // ****************************************************************
  // Storage
  // ****************************************************************
  iex_file_mem u_file_mem (
    .clock (clock),
    .rstn  (rstn),
    .ce    (ce),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  iex_ret_stack u_ret_stack (
    .clock            (clock),
    .rstn             (rstn),
    .ce               (ce),
    .push             (stk_push),
    .pop              (stk_pop),
    .push_data        (pc_reg + 13'h0001),
    .stack_head_entry (stack_head_entry)
  );

endmodule : iex_core

/* logic/iex_pkg.sv */
// Shared constants and types of the instruction execution subset block.
// Assumes one 10 MHz core clock and an AXI4-Lite master for software access.
package iex_pkg;

  // ****************************************************************
  // Widths and depths
  // ****************************************************************
  localparam int unsigned IEX_AXI_AW   = 8;
  localparam int unsigned IEX_DATA_W   = 8;
  localparam int unsigned IEX_FADDR_W  = 7;   // File addresses 0..127
  localparam int unsigned IEX_FDEPTH   = 128;
  localparam int unsigned IEX_PC_W     = 13;
  localparam int unsigned IEX_STK_AW   = 3;   // Eight return levels
  localparam int unsigned IEX_WDOG_W   = 8;
  localparam int unsigned IEX_PRE_W    = 8;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] IEX_OFS_CMD    = 8'h00;
  localparam logic [7:0] IEX_OFS_WREG   = 8'h04;
  localparam logic [7:0] IEX_OFS_STATUS = 8'h08;
  localparam logic [7:0] IEX_OFS_PC     = 8'h0c;
  localparam logic [7:0] IEX_OFS_WDOG   = 8'h10;
  localparam logic [7:0] IEX_OFS_FADDR  = 8'h14;
  localparam logic [7:0] IEX_OFS_FDATA  = 8'h18;
  localparam logic [7:0] IEX_OFS_WAKE   = 8'h1c;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned IEX_CMD_W     = 20;
  localparam int unsigned IEX_FLAGS_W   = 5;
  localparam int unsigned IEX_ST_BUSY   = 8;
  localparam int unsigned IEX_ST_HALT   = 9;
  localparam int unsigned IEX_WDOG_LSB  = 8;   // Counter above prescaler
  localparam int unsigned IEX_WAKE_BIT  = 0;

  localparam logic [1:0] IEX_RESP_OKAY   = 2'h0;
  localparam logic [1:0] IEX_RESP_SLVERR = 2'h2;

  localparam logic [IEX_PC_W-1:0]   IEX_PC_RST  = 13'h0000;
  localparam logic [IEX_DATA_W-1:0] IEX_W_RST   = 8'h00;
  localparam logic [IEX_WDOG_W-1:0] IEX_WDOG_CLR = 8'h00;
  localparam logic [IEX_PRE_W-1:0]  IEX_PRE_CLR = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    IEX_OP_NOP                   = 4'h0,
    IEX_OP_SLEEP                 = 4'h1,
    IEX_OP_RETURN                = 4'h2,
    IEX_ROTATE_RIGHT_CARRY_INSTR = 4'h3,
    IEX_SUBTRACT_LITERAL_INSTR   = 4'h4,
    IEX_SUBTRACT_FILE_INSTR      = 4'h5,
    IEX_OP_PUSH                  = 4'h6
  } iex_op_e;

  typedef struct packed {
    logic [IEX_DATA_W-1:0]  literal;
    logic [IEX_FADDR_W-1:0] faddr;
    logic                   dest;     // 0: working reg, 1: file reg
    iex_op_e                op;
  } iex_cmd_s;

  typedef struct packed {
    logic watchdog_expiry_flag_n;
    logic power_down_flag_n;
    logic zero_flag;
    logic digit_carry_flag;
    logic carry_flag;
  } iex_flags_s;

  localparam iex_flags_s IEX_FLAGS_RST = 5'h18;

  typedef enum logic [2:0] {
    IEX_EX_IDLE  = 3'b000,
    IEX_EX_FETCH = 3'b001,
    IEX_EX_EXEC  = 3'b010,
    IEX_EX_RET2  = 3'b011,
    IEX_EX_HALT  = 3'b100
  } iex_state_e;

endpackage : iex_pkg

/* logic/iex_file_mem.sv */
// File register memory, 128 bytes, one write and one registered read port.
// Assumes the caller never needs the read data in the cycle of the address.
`timescale 1ns/1ns
module iex_file_mem
  import iex_pkg::*;
(
  input  wire logic                   clock,  // Core clock
  input  wire logic                   rstn,   // Sync reset, active low
  input  wire logic                   ce,     // Clock enable
  input  wire logic                   we,     // Write strobe
  input  wire logic [IEX_FADDR_W-1:0] waddr,  // Write address
  input  wire logic [IEX_DATA_W-1:0]  wdata,  // Write data
  input  wire logic [IEX_FADDR_W-1:0] raddr,  // Read address
  output logic      [IEX_DATA_W-1:0]  rdata   // Read data, registered
);

  logic [IEX_DATA_W-1:0] mem_array [IEX_FDEPTH];

  always_ff @(posedge clock) begin
    if (ce && we) begin
      mem_array[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= mem_array[raddr];
    end
  end

endmodule : iex_file_mem

/* logic/iex_ret_stack.sv */
// Circular hardware return stack of eight program counter values.
// Overflow silently wraps; the caller never pushes and pops together.
`timescale 1ns/1ns
module iex_ret_stack
  import iex_pkg::*;
(
  input  wire logic                clock,      // Core clock
  input  wire logic                rstn,       // Sync reset, active low
  input  wire logic                ce,         // Clock enable
  input  wire logic                push,       // Push strobe
  input  wire logic                pop,        // Pop strobe
  input  wire logic [IEX_PC_W-1:0] push_data,  // Value pushed
  output logic      [IEX_PC_W-1:0] stack_head_entry  // Current top entry
);

  logic [IEX_PC_W-1:0]   stk_reg [2**IEX_STK_AW];
  logic [IEX_STK_AW-1:0] ptr_reg;
  logic [IEX_STK_AW-1:0] ptr_next;
  logic [IEX_STK_AW-1:0] head_idx;

  always_comb begin
    head_idx = ptr_reg - 3'h1;
    ptr_next = ptr_reg;
    if (push) begin
      ptr_next = ptr_reg + 3'h1;
    end else if (pop) begin
      ptr_next = head_idx;
    end
    stack_head_entry = stk_reg[head_idx];
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ptr_reg <= 3'h0;
    end else if (ce) begin
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge clock) begin
    if (ce && push) begin
      stk_reg[ptr_reg] <= push_data;
    end
  end

endmodule : iex_ret_stack

/* dv/iex_chk.sv */
// Port checks of the execution subset block.
// Assumes it is bound into iex_core; one clock.
`timescale 1ns/1ns
module iex_chk (
  input wire logic clock,          // Core clock
  input wire logic rstn,           // Reset, low
  input wire logic s_axi_awready,  // Aw ready
  input wire logic s_axi_wready,   // W ready
  input wire logic s_axi_bvalid,   // B valid
  input wire logic s_axi_bready,   // B ready
  input wire logic s_axi_arvalid,  // Ar valid
  input wire logic s_axi_arready,  // Ar ready
  input wire logic s_axi_rvalid,   // R valid
  input wire logic s_axi_rready,   // R ready
  input wire logic osc_run         // Osc enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_wait;
    !s_axi_arready ##[1:5] s_axi_rvalid;
  endsequence
  rst_vals_a: assert property ($rose(rstn) |-> osc_run && s_axi_arready)
    else $error("bad state after reset");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  rd_lat_a: assert property (rd_take |=> rd_wait)
    else $error("read answer late");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during answer");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read not closed");
  wr_commit_a: assert property ($rose(s_axi_bvalid) |->
    !$past(s_axi_awready) && s_axi_awready) else $error("bad commit");
  halt_osc_a: assert property ($fell(osc_run) |=> !osc_run)
    else $error("oscillator restarted at once");
endmodule : iex_chk
bind iex_core iex_chk i_chk (.clock, .rstn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .osc_run);

/* dv/test_instr_exec_subset.sv */
// Directed bench of the execution subset block over AXI4-Lite.
// Assumes iex_core with its checker bound; no partner model.
`timescale 1ns/1ns
module test_instr_exec_subset
  import iex_pkg::*;
;
  logic        clock, rstn, ce, osc_run;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          miscompares, checks;
  iex_core i_dut (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Ready lines fall while a request is held, so no edge ever takes it twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = IEX_RESP_OKAY);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    chk({31'h0, s_axi_bvalid}, 32'h1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = IEX_RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    chk({31'h0, s_axi_rvalid}, 32'h1);
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  task automatic run(input iex_op_e op, input logic d, input logic [6:0] f,
                     input logic [7:0] k);
    wr(IEX_OFS_CMD, {12'h0, iex_cmd_s'{k, f, d, op}});
    repeat (4) @(posedge clock);
  endtask : run
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    finish_test();
  end
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {ce, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7f;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    rd(IEX_OFS_STATUS, 32'h18);
    $display("test reset done");
    wr(IEX_OFS_WREG, 32'h05);
    run(IEX_SUBTRACT_LITERAL_INSTR, 1'b0, 7'h00, 8'h03);
    rd(IEX_OFS_WREG, 32'hfe);
    rd(IEX_OFS_STATUS, 32'h18);
    wr(IEX_OFS_WREG, 32'h10);
    run(IEX_SUBTRACT_LITERAL_INSTR, 1'b0, 7'h00, 8'h10);
    rd(IEX_OFS_STATUS, 32'h1f);
    $display("test literal done");
    wr(IEX_OFS_FADDR, 32'h7f);
    wr(IEX_OFS_FDATA, 32'h20);
    wr(IEX_OFS_WREG, 32'h01);
    run(IEX_SUBTRACT_FILE_INSTR, 1'b1, 7'h7f, 8'h00);
    rd(IEX_OFS_FDATA, 32'h1f);
    rd(IEX_OFS_STATUS, 32'h19);
    run(IEX_SUBTRACT_FILE_INSTR, 1'b0, 7'h7f, 8'h00);
    rd(IEX_OFS_WREG, 32'h1e);
    rd(IEX_OFS_STATUS, 32'h1b);
    $display("test file done");
    wr(IEX_OFS_FDATA, 32'h02);
    wr(IEX_OFS_STATUS, 32'h1d);
    run(IEX_ROTATE_RIGHT_CARRY_INSTR, 1'b1, 7'h7f, 8'h00);
    rd(IEX_OFS_FDATA, 32'h81);
    rd(IEX_OFS_STATUS, 32'h1c);
    run(IEX_ROTATE_RIGHT_CARRY_INSTR, 1'b0, 7'h7f, 8'h00);
    rd(IEX_OFS_WREG, 32'h40);
    rd(IEX_OFS_STATUS, 32'h1d);
    $display("test rotate done");
    wr(IEX_OFS_PC, 32'h0123);
    run(IEX_OP_PUSH, 1'b0, 7'h00, 8'h00);
    wr(IEX_OFS_PC, 32'h0500);
    run(IEX_OP_RETURN, 1'b0, 7'h00, 8'h00);
    rd(IEX_OFS_PC, 32'h0124);
    rd(IEX_OFS_STATUS, 32'h1d);
    $display("test return done");
    wr(IEX_OFS_STATUS, 32'h07);
    run(IEX_OP_SLEEP, 1'b0, 7'h00, 8'h00);
    chk({31'h0, osc_run}, 32'h0);
    rd(IEX_OFS_STATUS, 32'h217);
    rd(IEX_OFS_WDOG, 32'h0);
    wr(IEX_OFS_CMD, 32'h3, IEX_RESP_SLVERR);
    rd(IEX_OFS_WDOG, 32'h0);
    wr(IEX_OFS_WAKE, 32'h1);
    repeat (4) @(posedge clock);
    chk({31'h0, osc_run}, 32'h1);
    $display("test halt done");
    rd(8'h20, 32'h0, IEX_RESP_SLVERR);
    wr(IEX_OFS_WDOG, 32'h0, IEX_RESP_SLVERR);
    $display("test errors done");
    finish_test();
  end
endmodule : test_instr_exec_subset
